// file: fpsa_defines.svh
// Constants for the floating-point status and arithmetic block
`ifndef FPSA_DEFINES_SVH
`define FPSA_DEFINES_SVH
`define FPSA_ST_BUSY 7
`define FPSA_ST_SIGN 6
`define FPSA_ST_ZERO 5
`define FPSA_ST_DIVX 3
`define FPSA_ST_UNDF 2
`define FPSA_ST_OVFL 1
`define FPSA_STATUS_RESET 8'h00
`define FPSA_BIAS 8'h7F
`define FPSA_OP_ADD 2'h0
`define FPSA_OP_SUB 2'h1
`define FPSA_OP_MUL 2'h2
`define FPSA_OP_DIV 2'h3
`endif

// file: fpsa_pkg.sv
// Types for the floating-point status and arithmetic block
package fpsa_pkg;
	typedef enum {
		FPSA_IDLE,
		FPSA_ALIGN,
		FPSA_ADDSUB,
		FPSA_MUL,
		FPSA_DIV,
		FPSA_NORM,
		FPSA_ROUND,
		FPSA_DONE
	} fpsa_state_type;

	typedef struct packed {
		fpsa_state_type state;
		logic [7:0] status;
		logic sa;
		logic sb;
		logic [9:0] ea;
		logic [9:0] eb;
		logic [27:0] ma;
		logic [27:0] mb;
		logic [47:0] acc;
		logic [4:0] cnt;
		logic [1:0] op;
		logic subnorm;
		logic [31:0] result;
		logic done;
	} fpsa_regs_type;
endpackage : fpsa_pkg

// file: fpsa_core.sv
// Status word and single-precision add, subtract, multiply and divide datapath
//
// Contract
// [RQ1] Status word: busy,sign,zero,divx,underflow,overflow bits
// [RQ2] Divide exception only on zero divisor
// [RQ3] Reset clears whole status word
// [RQ4] Clear-status command zeroes status, stack untouched
// [RQ5] Busy set on issue until done
// [RQ6] New command clears bits zero to six
// [RQ7] Host trusts flags only when not busy
// [RQ8] Zero flag when top result all zeros
// [RQ9] Sign flag when top result negative
// [RQ10] Unpack sign, exponent, mantissa with hidden one
// [RQ11] Exponent coded excess 127
// [RQ12] Subtract inverts top operand sign, then adds
// [RQ13] Align smaller exponent; larger gives sign, exponent
// [RQ14] Like signs: add, shift right, overflow check
// [RQ15] Unlike signs: subtract, normalize left, underflow check
// [RQ16] Multiply by zero gives zero immediately
// [RQ17] Multiply adds unbiased exponents, checks, rebiases
// [RQ18] Product and quotient sign is sign xor
// [RQ19] Product top bit set: shift, increment, check
// [RQ20] Zero divisor raises exception; zero dividend zero
// [RQ21] Divide subtracts exponents, checks, divides, normalizes
// [RQ22] Halfway results round to even
// [RQ23] Step sequencing and cycle counts are free
`timescale 1ns/1ps
`include "fpsa_defines.svh"

module fpsa_core (
	input wire logic i_clk,                // Device clock
	input wire logic i_srst,               // Synchronous reset, active high
	input wire logic i_cmd_valid,          // Arithmetic command issue pulse
	input wire logic [1:0] i_cmd_op,       // Add, sub, mul or div
	input wire logic i_flag_wipe_command,  // Clear-status command pulse
	input wire logic [31:0] i_stack_top_operand,    // Top of stack operand
	input wire logic [31:0] i_second_stack_operand, // Next on stack operand
	output logic [7:0] o_arith_status_word,  // Status word
	output logic [31:0] o_result,            // Result for top of stack
	output logic o_result_valid,             // Result write pulse
	output logic o_cmd_ready                 // Idle, can take a command
);
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic is_zero_op(input logic [31:0] v);
		is_zero_op = (v[30:23] == 8'h00);
	endfunction : is_zero_op

	fpsa_pkg::fpsa_regs_type r_reg, r_next;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [9:0] e;
		logic lsb, g, rb, st;
		logic [24:0] rnd;
		e = 10'h000;
		lsb = 1'b0;
		g = 1'b0;
		rb = 1'b0;
		st = 1'b0;
		rnd = 25'h0000000;
		r_next = r_reg;
		r_next.done = 1'b0;
		case (r_reg.state)
			fpsa_pkg::FPSA_IDLE: begin
				if (i_flag_wipe_command) begin
					r_next.status = `FPSA_STATUS_RESET; // see [RQ4]
				end else if (i_cmd_valid) begin
					r_next.status = 8'h80; // see [RQ5] see [RQ6]
					r_next.op = i_cmd_op;
					r_next.subnorm = 1'b0;
					// Unpack with hidden one, three guard bits below
					r_next.sa = i_stack_top_operand[31] ^
						(i_cmd_op == `FPSA_OP_SUB); // see [RQ12]
					r_next.sb = i_second_stack_operand[31];
					r_next.ea = {2'b00, i_stack_top_operand[30:23]}; // see [RQ10] see [RQ11]
					r_next.eb = {2'b00, i_second_stack_operand[30:23]};
					r_next.ma = {1'b0, 1'b1, i_stack_top_operand[22:0], 3'b000};
					r_next.mb = {1'b0, 1'b1, i_second_stack_operand[22:0], 3'b000};
					r_next.cnt = 5'h00;
					r_next.acc = 48'h000000000000;
					case (i_cmd_op)
						`FPSA_OP_MUL: begin
							if (is_zero_op(i_stack_top_operand) ||
								is_zero_op(i_second_stack_operand)) begin
								r_next.result = 32'h00000000; // see [RQ16]
								r_next.state = fpsa_pkg::FPSA_DONE;
							end else begin
								r_next.state = fpsa_pkg::FPSA_MUL;
							end
						end
						`FPSA_OP_DIV: begin
							if (is_zero_op(i_stack_top_operand)) begin
								r_next.status[`FPSA_ST_DIVX] = 1'b1; // see [RQ2] see [RQ20]
								r_next.result = i_second_stack_operand;
								r_next.state = fpsa_pkg::FPSA_DONE;
							end else if (is_zero_op(i_second_stack_operand)) begin
								r_next.result = 32'h00000000; // see [RQ20]
								r_next.state = fpsa_pkg::FPSA_DONE;
							end else begin
								r_next.state = fpsa_pkg::FPSA_DIV;
							end
						end
						default: begin
							r_next.state = fpsa_pkg::FPSA_ALIGN;
						end
					endcase
				end
			end
			fpsa_pkg::FPSA_ALIGN: begin
				// One shift per cycle, lost bits kept sticky; see [RQ23]
				if (r_reg.ea < r_reg.eb) begin // see [RQ13]
					r_next.ma = {1'b0, r_reg.ma[27:2], r_reg.ma[1] | r_reg.ma[0]};
					r_next.ea = r_reg.ea + 10'h001;
				end else if (r_reg.eb < r_reg.ea) begin
					r_next.mb = {1'b0, r_reg.mb[27:2], r_reg.mb[1] | r_reg.mb[0]};
					r_next.eb = r_reg.eb + 10'h001;
				end else begin
					r_next.state = fpsa_pkg::FPSA_ADDSUB;
				end
			end
			fpsa_pkg::FPSA_ADDSUB: begin
				r_next.state = fpsa_pkg::FPSA_NORM;
				if (r_reg.sa == r_reg.sb) begin
					r_next.ma = r_reg.ma + r_reg.mb; // see [RQ14]
				end else if (r_reg.ma >= r_reg.mb) begin
					r_next.ma = r_reg.ma - r_reg.mb; // see [RQ15]
				end else begin
					r_next.ma = r_reg.mb - r_reg.ma;
					r_next.sa = r_reg.sb;
				end
				if (r_reg.sa != r_reg.sb && r_reg.ma == r_reg.mb) begin
					r_next.result = 32'h00000000;
					r_next.state = fpsa_pkg::FPSA_DONE;
				end
			end
			fpsa_pkg::FPSA_MUL: begin
				// Unbiased sum in 10 bits; top bits judge range
				e = r_reg.ea + r_reg.eb - {2'b00, `FPSA_BIAS} - {2'b00, `FPSA_BIAS};
				r_next.sa = r_reg.sa ^ r_reg.sb; // see [RQ18]
				r_next.acc = r_reg.ma[26:3] * r_reg.mb[26:3];
				if ($signed(e) > 10'sd127) begin
					r_next.status[`FPSA_ST_OVFL] = 1'b1; // see [RQ17]
					r_next.state = fpsa_pkg::FPSA_DONE;
				end else if ($signed(e) < -10'sd126) begin
					r_next.status[`FPSA_ST_UNDF] = 1'b1;
					r_next.state = fpsa_pkg::FPSA_DONE;
				end else begin
					r_next.ea = e + {2'b00, `FPSA_BIAS};
					r_next.state = fpsa_pkg::FPSA_NORM;
				end
			end
			fpsa_pkg::FPSA_DIV: begin
				// Restoring division, one quotient bit per cycle
				if (r_reg.cnt == 5'h00) begin
					e = r_reg.eb - r_reg.ea; // see [RQ21]
					r_next.sa = r_reg.sa ^ r_reg.sb; // see [RQ18]
					if ($signed(e) > 10'sd127) begin
						r_next.status[`FPSA_ST_OVFL] = 1'b1;
						r_next.state = fpsa_pkg::FPSA_DONE;
					end else if ($signed(e) < -10'sd127) begin
						r_next.status[`FPSA_ST_UNDF] = 1'b1;
						r_next.state = fpsa_pkg::FPSA_DONE;
					end
					r_next.ea = e + {2'b00, `FPSA_BIAS};
				end
				if (r_reg.mb >= r_reg.ma) begin
					r_next.mb = (r_reg.mb - r_reg.ma) << 1;
					r_next.acc = {r_reg.acc[46:0], 1'b1};
				end else begin
					r_next.mb = r_reg.mb << 1;
					r_next.acc = {r_reg.acc[46:0], 1'b0};
				end
				r_next.cnt = r_reg.cnt + 5'h01;
				if (r_reg.cnt == 5'h1B) begin
					// Quotient plus sticky from remainder
					// Integer quotient bit lands on the hidden-one position
					r_next.ma = {1'b0, r_next.acc[27:2],
						|{r_next.acc[1:0], (r_next.mb != 28'h0000000)}};
					r_next.state = fpsa_pkg::FPSA_NORM;
				end
			end
			fpsa_pkg::FPSA_NORM: begin
				if (r_reg.op == `FPSA_OP_MUL) begin
					// Product of two 1.x values into 1.x with guard bits
					if (r_reg.acc[47]) begin // see [RQ19]
						r_next.ma = {1'b0, r_reg.acc[47:22], |r_reg.acc[21:0]};
						r_next.ea = r_reg.ea + 10'h001;
					end else begin
						r_next.ma = {1'b0, r_reg.acc[46:21], |r_reg.acc[20:0]};
					end
					r_next.op = `FPSA_OP_ADD;
				end else if (r_reg.ma[27]) begin
					r_next.ma = {1'b0, r_reg.ma[27:2], r_reg.ma[1] | r_reg.ma[0]}; // see [RQ14]
					r_next.ea = r_reg.ea + 10'h001;
				end else if (!r_reg.ma[26]) begin
					r_next.ma = r_reg.ma << 1; // see [RQ15] see [RQ21]
					r_next.ea = r_reg.ea - 10'h001;
					r_next.subnorm = 1'b1;
				end else begin
					r_next.state = fpsa_pkg::FPSA_ROUND;
				end
			end
			fpsa_pkg::FPSA_ROUND: begin
				lsb = r_reg.ma[3];
				g = r_reg.ma[2];
				rb = r_reg.ma[1];
				st = r_reg.ma[0];
				// Round to nearest, ties to even
				rnd = {1'b0, r_reg.ma[26:3]} +
					{24'h000000, g & (rb | st | lsb)}; // see [RQ22]
				e = r_reg.ea;
				if (rnd[24]) begin
					rnd = {1'b0, rnd[24:1]};
					e = e + 10'h001;
				end
				if ($signed(e) > 10'sd254) begin
					r_next.status[`FPSA_ST_OVFL] = 1'b1; // see [RQ14] see [RQ19]
				end else if ($signed(e) < 10'sd1) begin
					r_next.status[`FPSA_ST_UNDF] = 1'b1; // see [RQ15] see [RQ21]
				end
				r_next.result = {r_reg.sa, e[7:0], rnd[22:0]};
				r_next.state = fpsa_pkg::FPSA_DONE;
			end
			fpsa_pkg::FPSA_DONE: begin
				r_next.status[`FPSA_ST_BUSY] = 1'b0; // see [RQ5]
				r_next.status[`FPSA_ST_ZERO] = (r_reg.result == 32'h00000000); // see [RQ8]
				r_next.status[`FPSA_ST_SIGN] = r_reg.result[31]; // see [RQ9]
				r_next.done = 1'b1;
				r_next.state = fpsa_pkg::FPSA_IDLE;
			end
			default: begin
				r_next.state = fpsa_pkg::FPSA_IDLE;
			end
		endcase
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r_reg <= '0; // see [RQ3]
			r_reg.state <= fpsa_pkg::FPSA_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_arith_status_word = r_reg.status; // see [RQ1] see [RQ7]
	assign o_result = r_reg.result;
	assign o_result_valid = r_reg.done;
	assign o_cmd_ready = (r_reg.state == fpsa_pkg::FPSA_IDLE);
endmodule : fpsa_core

// file: fpsa_core_properties.sv
// Port assertions for the arithmetic core
`timescale 1ns/1ps
`include "fpsa_defines.svh"

module fpsa_core_properties (
	input wire logic i_clk, // Device clock
	input wire logic i_srst, // Reset
	input wire logic i_cmd_valid, // Command pulse
	input wire logic [1:0] i_cmd_op, // Operation
	input wire logic i_flag_wipe_command, // Clear-status pulse
	input wire logic [31:0] i_stack_top_operand, // Top operand
	input wire logic [31:0] i_second_stack_operand, // Second operand
	input wire logic [7:0] o_arith_status_word, // Status word
	input wire logic [31:0] o_result, // Result
	input wire logic o_result_valid, // Result pulse
	input wire logic o_cmd_ready // Idle
);
	logic [1:0] last_op_reg;
	wire logic issue = i_cmd_valid && o_cmd_ready && !i_flag_wipe_command;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	always_ff @(posedge i_clk) begin
		if (issue) begin
			last_op_reg <= i_cmd_op;
		end
	end
	sequence s_mul_zero;
		issue && i_cmd_op == `FPSA_OP_MUL && (i_stack_top_operand == 32'h0 ||
			i_second_stack_operand == 32'h0);
	endsequence
	sequence s_div_zero;
		issue && i_cmd_op == `FPSA_OP_DIV && i_stack_top_operand == 32'h0;
	endsequence
	a_reset_clears: assert property (disable iff (1'b0) i_srst |=> o_arith_status_word == 8'h00)
		else $error("status not clear after reset");
	a_wipe_clears: assert property (i_flag_wipe_command && o_cmd_ready |=> o_arith_status_word == 8'h00)
		else $error("status not clear after wipe");
	a_issue_busy: assert property (issue && !(i_cmd_op == `FPSA_OP_DIV && i_stack_top_operand[30:23] == 8'h00) |=> o_arith_status_word == 8'h80 && !o_cmd_ready)
		else $error("issue did not set busy alone");
	a_done_bounded: assert property (issue |-> ##[2:1000] o_result_valid)
		else $error("command never finished");
	a_divx_cause: assert property (o_result_valid && o_arith_status_word[3] |-> last_op_reg == `FPSA_OP_DIV)
		else $error("divide exception outside divide");
	a_zero_flag: assert property (o_result_valid && !o_arith_status_word[3] |-> o_arith_status_word[5] == (o_result == 32'h0))
		else $error("zero flag wrong");
	a_sign_flag: assert property (o_result_valid && !o_arith_status_word[3] |-> o_arith_status_word[6] == o_result[31])
		else $error("sign flag wrong");
	a_mul_zero: assert property (s_mul_zero |-> ##2 o_result_valid && o_result == 32'h0)
		else $error("zero product not immediate");
	a_div_zero: assert property (s_div_zero |-> ##2 o_result_valid && o_arith_status_word[3])
		else $error("zero divisor not flagged");
endmodule : fpsa_core_properties

bind fpsa_core fpsa_core_properties i_props (.i_clk(i_clk), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid),
	.i_cmd_op(i_cmd_op), .i_flag_wipe_command(i_flag_wipe_command),
	.i_stack_top_operand(i_stack_top_operand), .i_second_stack_operand(i_second_stack_operand),
	.o_arith_status_word(o_arith_status_word), .o_result(o_result),
	.o_result_valid(o_result_valid), .o_cmd_ready(o_cmd_ready));

// file: fpsa_host_model.sv
// Host model that issues commands and reads flags once idle
`timescale 1ns/1ps

module fpsa_host_model (
	input wire logic i_clk, // Device clock
	input wire logic i_ready, // Device idle
	input wire logic i_valid, // Result pulse
	input wire logic [7:0] i_status, // Status word
	input wire logic [31:0] i_result, // Result word
	output logic o_cmd_valid, // Command pulse
	output logic o_wipe, // Clear-status pulse
	output logic [1:0] o_op, // Operation
	output logic [31:0] o_tos, // Top operand
	output logic [31:0] o_nos // Second operand
);
	initial begin
		{o_cmd_valid, o_wipe, o_op, o_tos, o_nos} = '0;
	end
	task automatic run(input logic [1:0] op, input logic [31:0] a, input logic [31:0] b,
		input logic w, output logic [7:0] st, output logic [31:0] r);
		int n;
		n = 0;
		while (!i_ready) @(posedge i_clk) #1;
		o_op = op;
		o_tos = a;
		o_nos = b;
		o_cmd_valid = !w;
		o_wipe = w;
		@(posedge i_clk) #1;
		o_cmd_valid = 1'b0;
		o_wipe = 1'b0;
		while (!w && !i_valid && n < 1000) begin
			@(posedge i_clk) #1;
			n++;
		end
		st = i_status;
		r = i_result;
	endtask : run
endmodule : fpsa_host_model

// file: fpsa_core_bench.sv
// Self-checking testbench for the arithmetic core
`timescale 1ns/1ps
`include "fpsa_defines.svh"

module fpsa_core_bench;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic cmd_valid, wipe, result_valid, cmd_ready;
	logic [1:0] op;
	logic [31:0] stack_top_operand, second_stack_operand, result;
	logic [7:0] status;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	always #50 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	fpsa_core i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_cmd_valid(cmd_valid), .i_cmd_op(op),
		.i_flag_wipe_command(wipe), .i_stack_top_operand(stack_top_operand), .i_second_stack_operand(second_stack_operand),
		.o_arith_status_word(status), .o_result(result), .o_result_valid(result_valid),
		.o_cmd_ready(cmd_ready));
	fpsa_host_model i_host (.i_clk(i_clk), .i_ready(cmd_ready), .i_valid(result_valid),
		.i_status(status), .i_result(result), .o_cmd_valid(cmd_valid), .o_wipe(wipe),
		.o_op(op), .o_tos(stack_top_operand), .o_nos(second_stack_operand));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic do_op(input logic [1:0] o, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] r, input logic [7:0] s, input logic [7:0] m);
		logic [7:0] st;
		logic [31:0] res;
		i_host.run(o, a, b, 1'b0, st, res);
		check({24'h0, st & m}, {24'h0, s});
		check(res & {32{m == 8'hFF}}, r & {32{m == 8'hFF}});
	endtask : do_op
	task automatic t_reset;
		check({24'h0, status}, 32'h0);
		check({31'h0, cmd_ready}, 32'h1);
	endtask : t_reset
	task automatic t_add_sub;
		do_op(`FPSA_OP_ADD, 32'h3F800000, 32'h3F800000, 32'h40000000, 8'h00, 8'hFF);
		do_op(`FPSA_OP_ADD, 32'h3E800000, 32'h3FC00000, 32'h3FE00000, 8'h00, 8'hFF);
		do_op(`FPSA_OP_ADD, 32'h33800000, 32'h3F800000, 32'h3F800000, 8'h00, 8'hFF);
		do_op(`FPSA_OP_SUB, 32'h40400000, 32'h3F800000, 32'hC0000000, 8'h40, 8'hFF);
		do_op(`FPSA_OP_SUB, 32'h3FC00000, 32'h3FC00000, 32'h0, 8'h20, 8'hFF);
	endtask : t_add_sub
	task automatic t_mul;
		do_op(`FPSA_OP_MUL, 32'hC0400000, 32'h40000000, 32'hC0C00000, 8'h40, 8'hFF);
		do_op(`FPSA_OP_MUL, 32'h3FC00000, 32'h3FC00000, 32'h40100000, 8'h00, 8'hFF);
		do_op(`FPSA_OP_MUL, 32'h0, 32'h40000000, 32'h0, 8'h20, 8'hFF);
		do_op(`FPSA_OP_MUL, 32'h40000000, 32'h7F000000, 32'h0, 8'h02, 8'h8E);
		do_op(`FPSA_OP_MUL, 32'h00800000, 32'h00800000, 32'h0, 8'h04, 8'h8E);
	endtask : t_mul
	task automatic t_div;
		do_op(`FPSA_OP_DIV, 32'h40000000, 32'h40C00000, 32'h40400000, 8'h00, 8'hFF);
		do_op(`FPSA_OP_DIV, 32'h3FC00000, 32'h3F800000, 32'h3F2AAAAB, 8'h00, 8'hFF);
		do_op(`FPSA_OP_DIV, 32'h40000000, 32'h0, 32'h0, 8'h20, 8'hFF);
		do_op(`FPSA_OP_DIV, 32'h0, 32'h40000000, 32'h0, 8'h08, 8'h8E);
	endtask : t_div
	task automatic t_wipe;
		logic [7:0] st;
		logic [31:0] res;
		i_host.run(`FPSA_OP_ADD, 32'h0, 32'h0, 1'b1, st, res);
		check({24'h0, st}, 32'h0);
	endtask : t_wipe
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3) @(posedge i_clk);
		#1 i_srst = 1'b0;
		t_reset();
		t_add_sub();
		t_mul();
		t_div();
		t_wipe();
		tally_and_finish();
	end
endmodule : fpsa_core_bench
